/* design/gpg_pkg.sv */
// shared constants and carrier types for the eight-bit port with pin mux
package gpg_pkg;

    localparam int          PIN_W          = 8;
    localparam int          ADDR_W         = 6;

    // byte offsets from the port base
    localparam logic [5:0]  OFF_DATA       = 6'h00;
    localparam logic [5:0]  OFF_OUT_EN     = 6'h04;
    localparam logic [5:0]  OFF_FSEL_B     = 6'h0C;
    localparam logic [5:0]  OFF_FSEL_C     = 6'h10;
    localparam logic [5:0]  OFF_FSEL_D     = 6'h14;
    localparam logic [5:0]  OFF_OPEN_DRAIN = 6'h28;
    localparam logic [5:0]  OFF_PULLUP     = 6'h2C;
    localparam logic [5:0]  OFF_IN_EN      = 6'h38;

    // implemented bits and reset values
    localparam logic [7:0]  MASK_FULL      = 8'hFF;
    localparam logic [7:0]  MASK_FSEL_C    = 8'hF7;
    localparam logic [7:0]  MASK_FSEL_D    = 8'h40;
    localparam logic [7:0]  RST_REG        = 8'h00;

    // alternate-function bit positions, select register b
    localparam int          POS_IRQ_ONE    = 7;
    localparam int          POS_SER3_CLK   = 6;
    localparam int          POS_SER3_RX    = 5;
    localparam int          POS_SER3_TX    = 4;
    localparam int          POS_IRQ_ZERO   = 3;
    localparam int          POS_BUS0_CLK   = 2;
    localparam int          POS_BUS0_SCL   = 1;
    localparam int          POS_BUS0_SDA   = 0;
    // select register c
    localparam int          POS_T9_B       = 7;
    localparam int          POS_T9_A       = 6;
    localparam int          POS_T8_B       = 5;
    localparam int          POS_T8_A       = 4;
    localparam int          POS_IRQ_EIGHT  = 2;
    localparam int          POS_T7_B       = 1;
    localparam int          POS_T7_A       = 0;
    // select register d
    localparam int          POS_SER3_CTS   = 6;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } gpg_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
        logic [1:0]  response;
    } gpg_avs_rsp_t;

    // drive side of the eight pads
    typedef struct packed {
        logic [7:0]  pinOut;
        logic [7:0]  pinOe;
        logic [7:0]  pullupOn;
        logic [7:0]  inBufOn;
    } gpg_pad_t;

    // outputs that peripherals offer to the pins
    typedef struct packed {
        logic        ser3ClkOut;
        logic        ser3ClkOe;
        logic        ser3TxOut;
        logic        bus0ClkOut;
        logic        bus0ClkOe;
        logic        bus0SclOut;
        logic        bus0SclOe;
        logic        bus0SdaOut;
        logic        bus0SdaOe;
    } gpg_alt_t;

    // pin levels handed to peripherals
    typedef struct packed {
        logic        extIrqOne;
        logic        extIrqZero;
        logic        extIrqEight;
        logic        ser3Clk;
        logic        ser3Rx;
        logic        ser3Cts;
        logic        bus0Clk;
        logic        bus0Scl;
        logic        bus0Sda;
        logic [5:0]  timerCapIn;
    } gpg_periph_t;

endpackage : gpg_pkg

/* design/gpg_pin_mux.sv */
// output routing of the eight pads: general-purpose latch or peripheral
`timescale 1ns/100ps
module gpg_pin_mux (
    input  wire logic [7:0]     dataReg,
    input  wire logic [7:0]     outEnReg,
    input  wire logic [7:0]     openDrainReg,
    input  wire logic [7:0]     fselB,
    input  wire logic [7:0]     fselC,
    input  wire logic [7:0]     fselD,
    input  wire gpg_pkg::gpg_alt_t alt,
    output logic      [7:0]     pinOut,
    output logic      [7:0]     pinOe
);

    logic [7:0] altOut;
    logic [7:0] altOe;
    logic [7:0] anySel;

    always_comb begin
        altOut = 8'h00;
        altOe  = 8'h00;
        // input-only functions (irq, rx, cts, capture) leave the driver off
        altOut[gpg_pkg::POS_SER3_CLK] = alt.ser3ClkOut;
        altOe[gpg_pkg::POS_SER3_CLK]  = alt.ser3ClkOe;
        altOut[gpg_pkg::POS_SER3_TX]  = alt.ser3TxOut;
        altOe[gpg_pkg::POS_SER3_TX]   = 1'b1;
        altOut[gpg_pkg::POS_BUS0_CLK] = alt.bus0ClkOut;
        altOe[gpg_pkg::POS_BUS0_CLK]  = alt.bus0ClkOe;
        altOut[gpg_pkg::POS_BUS0_SCL] = alt.bus0SclOut;
        altOe[gpg_pkg::POS_BUS0_SCL]  = alt.bus0SclOe;
        altOut[gpg_pkg::POS_BUS0_SDA] = alt.bus0SdaOut;
        altOe[gpg_pkg::POS_BUS0_SDA]  = alt.bus0SdaOe;
        anySel = fselB | fselC | fselD;
        for (int i = 0; i < 8; i++) begin
            // several selects at once is undefined use; register b wins
            if (fselB[i]) begin
                pinOut[i] = altOut[i];
                pinOe[i]  = altOe[i] & ~(openDrainReg[i] & altOut[i]);
            end else if (anySel[i]) begin
                pinOut[i] = 1'b0;
                pinOe[i]  = 1'b0;
            end else begin
                pinOut[i] = dataReg[i];
                pinOe[i]  = outEnReg[i] & ~(openDrainReg[i] & dataReg[i]);
            end
        end
    end

endmodule : gpg_pin_mux

/* design/gpg_port.sv */
// eight-bit general-purpose port with register bank and alternate-function mux
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
module gpg_port (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire gpg_pkg::gpg_avs_req_t avsReq,
    output logic                       avsWaitrequest,
    output logic [31:0]                avsReaddata,
    output logic [1:0]                 avsResponse,
    input  wire logic [7:0]            pinIn,
    output logic [7:0]                 pinOut,
    output logic [7:0]                 pinOe,
    output logic [7:0]                 pullupOn,
    output logic [7:0]                 inBufOn,
    input  wire logic                  stopMode,
    input  wire gpg_pkg::gpg_alt_t     altIn,
    output gpg_pkg::gpg_periph_t       periph
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]           dataReg;
        logic [7:0]           outEnReg;
        logic [7:0]           fselB;
        logic [7:0]           fselC;
        logic [7:0]           fselD;
        logic [7:0]           openDrainReg;
        logic [7:0]           pullupReg;
        logic [7:0]           inEnReg;
        gpg_pkg::gpg_avs_rsp_t rsp;
        gpg_pkg::gpg_pad_t    pad;
        gpg_pkg::gpg_periph_t per;
    } gpg_state_t;

    gpg_state_t st_r;
    gpg_state_t st_nxt;

    logic [7:0] muxOut;
    logic [7:0] muxOe;
    logic [7:0] inGated;
    logic       busReq;
    logic       accept;
    logic       wrLane0;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // true for the eight documented offsets; everything else is unmapped
    function automatic logic isMapped(input logic [5:0] a);
        case (a)
            gpg_pkg::OFF_DATA,
            gpg_pkg::OFF_OUT_EN,
            gpg_pkg::OFF_FSEL_B,
            gpg_pkg::OFF_FSEL_C,
            gpg_pkg::OFF_FSEL_D,
            gpg_pkg::OFF_OPEN_DRAIN,
            gpg_pkg::OFF_PULLUP,
            gpg_pkg::OFF_IN_EN:     isMapped = 1'b1;
            default:                isMapped = 1'b0;
        endcase
    endfunction : isMapped

    // write update of one register, limited to its implemented bits
    function automatic logic [7:0] wrField(input logic [7:0] old, input logic [7:0] wd,
                                           input logic [7:0] mask, input logic hit);
        wrField = hit ? (wd & mask) : old;
    endfunction : wrField

    ////////////////////////////////////////////////////////////////////////
    // pad routing

    gpg_pin_mux u_mux (
        .dataReg      (st_r.dataReg),
        .outEnReg     (st_r.outEnReg),
        .openDrainReg (st_r.openDrainReg),
        .fselB        (st_r.fselB),
        .fselC        (st_r.fselC),
        .fselD        (st_r.fselD),
        .alt          (altIn),
        .pinOut       (muxOut),
        .pinOe        (muxOe)
    );

    assign inGated = pinIn & st_r.inEnReg;
    assign busReq  = avsReq.read | avsReq.write;
    // the request is served in the cycle after it is first seen
    assign accept  = busReq & ~st_r.rsp.waitrequest;
    assign wrLane0 = accept & avsReq.write & avsReq.byteenable[0];

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0] rd;
        logic [5:0] a;
        rd     = 8'h00;
        a      = avsReq.address;
        st_nxt = st_r;

        // register writes take effect on the edge that sees waitrequest low
        st_nxt.dataReg      = wrField(st_r.dataReg, avsReq.writedata[7:0], gpg_pkg::MASK_FULL,
                                      wrLane0 && a == gpg_pkg::OFF_DATA);
        st_nxt.outEnReg     = wrField(st_r.outEnReg, avsReq.writedata[7:0], gpg_pkg::MASK_FULL,
                                      wrLane0 && a == gpg_pkg::OFF_OUT_EN);
        st_nxt.fselB        = wrField(st_r.fselB, avsReq.writedata[7:0], gpg_pkg::MASK_FULL,
                                      wrLane0 && a == gpg_pkg::OFF_FSEL_B);
        st_nxt.fselC        = wrField(st_r.fselC, avsReq.writedata[7:0], gpg_pkg::MASK_FSEL_C,
                                      wrLane0 && a == gpg_pkg::OFF_FSEL_C);
        st_nxt.fselD        = wrField(st_r.fselD, avsReq.writedata[7:0], gpg_pkg::MASK_FSEL_D,
                                      wrLane0 && a == gpg_pkg::OFF_FSEL_D);
        st_nxt.openDrainReg = wrField(st_r.openDrainReg, avsReq.writedata[7:0], gpg_pkg::MASK_FULL,
                                      wrLane0 && a == gpg_pkg::OFF_OPEN_DRAIN);
        st_nxt.pullupReg    = wrField(st_r.pullupReg, avsReq.writedata[7:0], gpg_pkg::MASK_FULL,
                                      wrLane0 && a == gpg_pkg::OFF_PULLUP);
        st_nxt.inEnReg      = wrField(st_r.inEnReg, avsReq.writedata[7:0], gpg_pkg::MASK_FULL,
                                      wrLane0 && a == gpg_pkg::OFF_IN_EN);

        // read mux; data offset returns the gated pin levels, not the latch
        case (a)
            gpg_pkg::OFF_DATA:       rd = inGated;
            gpg_pkg::OFF_OUT_EN:     rd = st_r.outEnReg;
            gpg_pkg::OFF_FSEL_B:     rd = st_r.fselB;
            gpg_pkg::OFF_FSEL_C:     rd = st_r.fselC;
            gpg_pkg::OFF_FSEL_D:     rd = st_r.fselD;
            gpg_pkg::OFF_OPEN_DRAIN: rd = st_r.openDrainReg;
            gpg_pkg::OFF_PULLUP:     rd = st_r.pullupReg;
            gpg_pkg::OFF_IN_EN:      rd = st_r.inEnReg;
            default:                 rd = 8'h00;
        endcase

        // one wait cycle, then one ready cycle per request
        st_nxt.rsp.waitrequest = ~(busReq & st_r.rsp.waitrequest);
        if (busReq && st_r.rsp.waitrequest) begin
            st_nxt.rsp.readdata = {24'h000000, avsReq.read ? rd : 8'h00};
            st_nxt.rsp.response = isMapped(a) ? gpg_pkg::RESP_OKAY : gpg_pkg::RESP_SLVERR;
        end

        // pads
        st_nxt.pad.pinOut   = muxOut;
        st_nxt.pad.pinOe    = muxOe;
        st_nxt.pad.pullupOn = st_r.pullupReg;
        st_nxt.pad.inBufOn  = st_r.inEnReg;

        // interrupts follow the input enable and stop mode, not the select
        st_nxt.per.extIrqOne   = inGated[gpg_pkg::POS_IRQ_ONE] & ~stopMode;
        st_nxt.per.extIrqZero  = inGated[gpg_pkg::POS_IRQ_ZERO] & ~stopMode;
        st_nxt.per.extIrqEight = inGated[gpg_pkg::POS_IRQ_EIGHT] & ~stopMode;

        // other inputs reach a peripheral only when its function is selected
        st_nxt.per.ser3Clk = inGated[gpg_pkg::POS_SER3_CLK] & st_r.fselB[gpg_pkg::POS_SER3_CLK];
        st_nxt.per.ser3Rx  = inGated[gpg_pkg::POS_SER3_RX] & st_r.fselB[gpg_pkg::POS_SER3_RX];
        st_nxt.per.ser3Cts = inGated[gpg_pkg::POS_SER3_CTS] & st_r.fselD[gpg_pkg::POS_SER3_CTS];
        st_nxt.per.bus0Clk = inGated[gpg_pkg::POS_BUS0_CLK] & st_r.fselB[gpg_pkg::POS_BUS0_CLK];
        st_nxt.per.bus0Scl = inGated[gpg_pkg::POS_BUS0_SCL] & st_r.fselB[gpg_pkg::POS_BUS0_SCL];
        st_nxt.per.bus0Sda = inGated[gpg_pkg::POS_BUS0_SDA] & st_r.fselB[gpg_pkg::POS_BUS0_SDA];
        st_nxt.per.timerCapIn = {inGated[gpg_pkg::POS_T9_B], inGated[gpg_pkg::POS_T9_A],
                                 inGated[gpg_pkg::POS_T8_B], inGated[gpg_pkg::POS_T8_A],
                                 inGated[gpg_pkg::POS_T7_B], inGated[gpg_pkg::POS_T7_A]}
                              & {st_r.fselC[gpg_pkg::POS_T9_B], st_r.fselC[gpg_pkg::POS_T9_A],
                                 st_r.fselC[gpg_pkg::POS_T8_B], st_r.fselC[gpg_pkg::POS_T8_A],
                                 st_r.fselC[gpg_pkg::POS_T7_B], st_r.fselC[gpg_pkg::POS_T7_A]};
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r                 <= '0;
            st_r.dataReg         <= gpg_pkg::RST_REG;
            st_r.outEnReg        <= gpg_pkg::RST_REG;
            st_r.fselB           <= gpg_pkg::RST_REG;
            st_r.fselC           <= gpg_pkg::RST_REG;
            st_r.fselD           <= gpg_pkg::RST_REG;
            st_r.pullupReg       <= gpg_pkg::RST_REG;
            st_r.inEnReg         <= gpg_pkg::RST_REG;
            st_r.rsp.waitrequest <= 1'b1;
            st_r.rsp.response    <= gpg_pkg::RESP_OKAY;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avsWaitrequest = st_r.rsp.waitrequest;
    assign avsReaddata    = st_r.rsp.readdata;
    assign avsResponse    = st_r.rsp.response;
    assign pinOut         = st_r.pad.pinOut;
    assign pinOe          = st_r.pad.pinOe;
    assign pullupOn       = st_r.pad.pullupOn;
    assign inBufOn        = st_r.pad.inBufOn;
    assign periph         = st_r.per;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    reset_all_off_a: assert property (
        $past(rst) |-> (pinOe == 8'h00 && pullupOn == 8'h00 && inBufOn == 8'h00))
        else $error("pads not quiet after reset");

    irq_follow_a: assert property (
        (!stopMode && st_r.inEnReg[gpg_pkg::POS_IRQ_ONE] && pinIn[gpg_pkg::POS_IRQ_ONE])
        |=> periph.extIrqOne)
        else $error("enabled pin did not reach interrupt one");

    irq_stop_a: assert property (
        stopMode |=> !periph.extIrqZero && !periph.extIrqOne && !periph.extIrqEight)
        else $error("interrupt forwarded in stop mode");

    upper_zero_a: assert property (
        !avsWaitrequest |-> avsReaddata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    wait_one_a: assert property (
        (busReq && avsWaitrequest) |=> !avsWaitrequest ##1 avsWaitrequest)
        else $error("waitrequest did not pulse low for one cycle");

    sel_d_mask_a: assert property (
        (wrLane0 && avsReq.address == gpg_pkg::OFF_FSEL_D)
        |=> st_r.fselD == (($past(avsReq.writedata[7:0])) & gpg_pkg::MASK_FSEL_D))
        else $error("select d kept an unimplemented bit");

    sel_c_bit3_a: assert property (st_r.fselC[3] == 1'b0)
        else $error("select c bit 3 set");

    od_write_a: assert property (
        (wrLane0 && avsReq.address == gpg_pkg::OFF_OPEN_DRAIN)
        |=> st_r.openDrainReg == $past(avsReq.writedata[7:0]))
        else $error("open-drain register not written");

    unmapped_err_a: assert property (
        (busReq && avsWaitrequest && !isMapped(avsReq.address))
        |=> avsResponse == gpg_pkg::RESP_SLVERR && avsReaddata == 32'h00000000)
        else $error("unmapped access not answered with error");

    gpio_drive_a: assert property (
        ((st_r.fselB | st_r.fselC | st_r.fselD) == 8'h00 && st_r.openDrainReg == 8'h00)
        |=> pinOe == $past(st_r.outEnReg) && pinOut == $past(st_r.dataReg))
        else $error("plain I/O pin driver mismatch");

    data_read_a: assert property (
        (busReq && avsWaitrequest && avsReq.read && avsReq.address == gpg_pkg::OFF_DATA)
        |=> avsReaddata[7:0] == $past(pinIn & st_r.inEnReg))
        else $error("data read not gated by input enable");

    // pad copies lag their registers by one edge; skip the edge right after reset
    pad_copy_a: assert property (
        !$past(rst) |-> inBufOn == $past(st_r.inEnReg) && pullupOn == $past(st_r.pullupReg))
        else $error("pull-up or input buffer enable does not follow its register");

    tx_drive_a: assert property (
        (st_r.fselB[gpg_pkg::POS_SER3_TX] && !st_r.openDrainReg[gpg_pkg::POS_SER3_TX])
        |=> pinOe[gpg_pkg::POS_SER3_TX] && pinOut[gpg_pkg::POS_SER3_TX] == $past(altIn.ser3TxOut))
        else $error("serial three transmit not driven on its pin");

    bus_clk_a: assert property (
        (st_r.fselB[gpg_pkg::POS_BUS0_CLK] && !st_r.openDrainReg[gpg_pkg::POS_BUS0_CLK])
        |=> pinOe[gpg_pkg::POS_BUS0_CLK] == $past(altIn.bus0ClkOe))
        else $error("bus clock enable not routed to its pin");

    cap_gate_a: assert property (
        st_r.fselC == 8'h00 |=> periph.timerCapIn == 6'h00)
        else $error("capture input reached timer without select");

    // input-only functions must never leave the plain driver on
    in_only_off_a: assert property (
        ((st_r.fselC | st_r.fselD) & ~st_r.fselB) != 8'h00
        |=> (pinOe & $past((st_r.fselC | st_r.fselD) & ~st_r.fselB)) == 8'h00)
        else $error("driver on for an input-only function");

endmodule : gpg_port

/* bench/gpg_board_model.sv */
// board side of the port: resolves each pad level from chip drive, external drive and pull-up
`timescale 1ns/100ps
module gpg_board_model (
    input  wire logic       clk,
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pullupOn,
    input  wire logic [7:0] extOe,
    input  wire logic [7:0] extVal,
    output logic      [7:0] pinLevel
);
    // a floating pad flips every cycle so that nothing can rely on a stale level
    logic [7:0] floatPat_r = 8'h55;

    always_ff @(posedge clk) begin
        floatPat_r <= ~floatPat_r;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOe[i]) begin
                pinLevel[i] = pinOut[i];
            end else if (extOe[i]) begin
                pinLevel[i] = extVal[i];
            end else if (pullupOn[i]) begin
                pinLevel[i] = 1'b1;
            end else begin
                pinLevel[i] = floatPat_r[i];
            end
        end
    end
endmodule : gpg_board_model

/* bench/tb_gpg_port.sv */
// self-checking bench for the eight-bit port with pin mux
`timescale 1ns/100ps
module tb_gpg_port;
    logic                  clk;
    logic                  rst;
    gpg_pkg::gpg_avs_req_t req;
    logic                  avsWaitrequest;
    logic [31:0]           avsReaddata;
    logic [1:0]            avsResponse;
    logic [7:0]            pinIn, pinOut, pinOe, pullupOn, inBufOn, extOe, extVal;
    logic                  stopMode;
    gpg_pkg::gpg_alt_t     altIn;
    gpg_pkg::gpg_periph_t  periph;
    int                    fails, n_tests, cyc;
    logic [31:0]           rd;
    logic [1:0]            rs;
    logic [5:0]            offs [8];
    logic [7:0]            masks [8];
    logic [5:0]            rsvd [7];

    gpg_port i_gpg_port (.clk(clk), .rst(rst), .avsReq(req), .avsWaitrequest(avsWaitrequest),
        .avsReaddata(avsReaddata), .avsResponse(avsResponse), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pullupOn(pullupOn), .inBufOn(inBufOn), .stopMode(stopMode),
        .altIn(altIn), .periph(periph));
    gpg_board_model i_gpg_board_model (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullupOn(pullupOn), .extOe(extOe), .extVal(extVal), .pinLevel(pinIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // the whole run is a few hundred cycles; this ceiling only catches a hung handshake
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // request held until the edge that samples waitrequest low, released after it
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
        req.read       <= !wr;
        req.write      <= wr;
        req.address    <= a;
        req.writedata  <= d;
        req.byteenable <= 4'hF;
        @(posedge clk);
        while (avsWaitrequest !== 1'b0) begin
            @(posedge clk);
        end
        rd = avsReaddata;
        rs = avsResponse;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] resp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({30'h0, rs}, {30'h0, resp});
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({pinOut, pinOe, pullupOn, inBufOn}, 32'h0);
        for (int i = 0; i < 8; i++) rdchk(offs[i], 32'h0, gpg_pkg::RESP_OKAY);
    endtask : t_reset

    task automatic t_regs;
        for (int i = 1; i < 8; i++) begin
            xfer(1'b1, offs[i], 32'hFFFF_FFFF);
            rdchk(offs[i], {24'h0, masks[i]}, gpg_pkg::RESP_OKAY);
            xfer(1'b1, offs[i], 32'h0);
        end
    endtask : t_regs

    task automatic t_unmapped;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, rsvd[i], 32'hFF);
            rdchk(rsvd[i], 32'h0, gpg_pkg::RESP_SLVERR);
        end
        rdchk(gpg_pkg::OFF_OUT_EN, 32'h0, gpg_pkg::RESP_OKAY);
    endtask : t_unmapped

    task automatic t_gpio;
        xfer(1'b1, gpg_pkg::OFF_OUT_EN, 32'hFF);
        xfer(1'b1, gpg_pkg::OFF_DATA, 32'hA5);
        repeat (3) @(posedge clk);
        chk({pinOut, pinOe}, 16'hA5FF);
        xfer(1'b1, gpg_pkg::OFF_IN_EN, 32'hFF);
        repeat (3) @(posedge clk);
        rdchk(gpg_pkg::OFF_DATA, 32'hA5, gpg_pkg::RESP_OKAY);
        xfer(1'b1, gpg_pkg::OFF_OPEN_DRAIN, 32'hFF);
        xfer(1'b1, gpg_pkg::OFF_PULLUP, 32'hFF);
        repeat (3) @(posedge clk);
        chk({pinOe, pullupOn}, 16'h5AFF);
        rdchk(gpg_pkg::OFF_DATA, 32'hA5, gpg_pkg::RESP_OKAY);
        for (int i = 0; i < 6; i++) xfer(1'b1, offs[i], 32'h0);
        xfer(1'b1, gpg_pkg::OFF_OPEN_DRAIN, 32'h0);
        xfer(1'b1, gpg_pkg::OFF_PULLUP, 32'h0);
    endtask : t_gpio

    task automatic t_input;
        extOe  <= 8'hFF;
        extVal <= 8'h3C;
        xfer(1'b1, gpg_pkg::OFF_IN_EN, 32'h0F);
        repeat (3) @(posedge clk);
        rdchk(gpg_pkg::OFF_DATA, 32'h0C, gpg_pkg::RESP_OKAY);
        chk({periph.extIrqOne, periph.extIrqZero, periph.extIrqEight, inBufOn}, 11'h30F);
        stopMode <= 1'b1;
        repeat (3) @(posedge clk);
        chk({periph.extIrqZero, periph.extIrqEight}, 2'h0);
        stopMode <= 1'b0;
    endtask : t_input

    task automatic t_alt;
        extOe            <= 8'h00;
        altIn.ser3TxOut  <= 1'b1;
        altIn.bus0ClkOe  <= 1'b1;
        altIn.bus0ClkOut <= 1'b0;
        xfer(1'b1, gpg_pkg::OFF_FSEL_B, 32'h14);
        repeat (3) @(posedge clk);
        chk({pinOe & 8'h14, pinOut & 8'h14}, 16'h1410);
        xfer(1'b1, gpg_pkg::OFF_FSEL_B, 32'h0);
        repeat (3) @(posedge clk);
        chk(pinOe, 8'h00);
        extOe  <= 8'hFF;
        extVal <= 8'hFF;
        xfer(1'b1, gpg_pkg::OFF_IN_EN, 32'hFF);
        xfer(1'b1, gpg_pkg::OFF_FSEL_C, 32'hF7);
        repeat (3) @(posedge clk);
        chk({periph.timerCapIn, periph.ser3Cts}, 7'h7E);
        xfer(1'b1, gpg_pkg::OFF_FSEL_C, 32'h0);
        xfer(1'b1, gpg_pkg::OFF_FSEL_D, 32'h40);
        repeat (3) @(posedge clk);
        chk({periph.timerCapIn, periph.ser3Cts}, 7'h01);
        xfer(1'b1, gpg_pkg::OFF_FSEL_D, 32'h0);
        xfer(1'b1, gpg_pkg::OFF_FSEL_B, 32'h21);
        repeat (3) @(posedge clk);
        chk({periph.ser3Rx, periph.bus0Sda, periph.bus0Scl}, 3'h6);
    endtask : t_alt

    // reset in mid-run, with selects and input enables still set
    task automatic t_rerst;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({pinOut, pinOe, pullupOn, inBufOn}, 32'h0);
        chk(periph, 32'h0);
        rdchk(gpg_pkg::OFF_FSEL_B, 32'h0, gpg_pkg::RESP_OKAY);
    endtask : t_rerst

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        offs  = '{gpg_pkg::OFF_DATA, gpg_pkg::OFF_OUT_EN, gpg_pkg::OFF_FSEL_B, gpg_pkg::OFF_FSEL_C,
                  gpg_pkg::OFF_FSEL_D, gpg_pkg::OFF_OPEN_DRAIN, gpg_pkg::OFF_PULLUP, gpg_pkg::OFF_IN_EN};
        masks = '{8'h00, 8'hFF, 8'hFF, 8'hF7, 8'h40, 8'hFF, 8'hFF, 8'hFF};
        rsvd  = '{6'h08, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h30, 6'h34};
        fails    = 0;
        n_tests  = 0;
        cyc      = 0;
        rst      = 1'b1;
        req      = '0;
        extOe    = 8'h00;
        extVal   = 8'h00;
        stopMode = 1'b0;
        altIn    = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_regs();
        t_unmapped();
        t_gpio();
        t_input();
        t_alt();
        t_rerst();
        finish_test();
    end
endmodule : tb_gpg_port
